// ==== hdl/cmd_sleep_pkg.sv ====
// constants for the command mode and sleep sequencer
// assumes a 50 MHz clock
package cmd_sleep_pkg;
    localparam int clk_hz = 50000000;
    localparam int tick_ms = 1;
    localparam int cycles_per_ms = clk_hz / 1000 * tick_ms;
    // register byte offsets
    localparam logic [7:0] off_ctrl = 8'h00;
    localparam logic [7:0] off_inact = 8'h04;
    localparam logic [7:0] off_guard = 8'h08;
    localparam logic [7:0] off_esc = 8'h0c;
    localparam logic [7:0] off_smode = 8'h10;
    localparam logic [7:0] off_pcount = 8'h14;
    localparam logic [7:0] off_plen = 8'h18;
    localparam logic [7:0] off_tbs = 8'h1c;
    localparam logic [7:0] off_sopt = 8'h20;
    localparam logic [7:0] off_status = 8'h24;
    localparam logic [7:0] off_addr_lo = 8'h28;
    localparam logic [7:0] off_addr_hi = 8'h2c;
    // reset values and legal limits
    localparam logic [15:0] inact_rst = 16'h0064;
    localparam logic [15:0] inact_min = 16'h0002;
    localparam logic [15:0] inact_max = 16'h028f;
    localparam logic [15:0] guard_rst = 16'h03e8;
    localparam logic [15:0] guard_min = 16'h0001;
    localparam logic [15:0] guard_max = 16'h0ce4;
    localparam logic [7:0] esc_rst = 8'h2b;
    localparam logic [2:0] smode_rst = 3'h0;
    localparam logic [15:0] pcount_rst = 16'h0001;
    localparam logic [15:0] plen_rst = 16'h0020;
    localparam logic [15:0] plen_min = 16'h0020;
    localparam logic [15:0] plen_max = 16'h0af0;
    localparam logic [15:0] tbs_rst = 16'h1388;
    localparam logic [15:0] tbs_max = 16'hfffe;
    localparam logic [7:0] sopt_rst = 8'h00;
    // sleep modes, options, counts, units and state encodings
    localparam logic [2:0] smode_off = 3'h0;
    localparam logic [2:0] smode_pin = 3'h1;
    localparam logic [2:0] smode_cyclic = 3'h4;
    localparam int sopt_wake_bit = 1;
    localparam int sopt_long_bit = 2;
    localparam int esc_count = 3;
    localparam int addr_bytes = 8;
    localparam int ms_per_inact = 100;
    localparam int ms_per_plen = 10;
    typedef enum logic [1:0] {
        cm_idle = 2'b00, cm_arm = 2'b01, cm_post = 2'b11, cm_cmd = 2'b10
    } cmd_state_t;
    typedef enum logic [1:0] {
        sl_awake = 2'b00, sl_sleep = 2'b01, sl_wake = 2'b11
    } sleep_state_t;
endpackage : cmd_sleep_pkg

// ==== hdl/addr_prefix.sv ====
// source address prefixer for outgoing payloads
// assumes valid/ready byte streams, same clock
`timescale 1ns/1ps
module addr_prefix (
    // clock
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // own address
    input wire logic [63:0] src_addr,
    // payload in
    input wire logic [7:0] in_data,
    input wire logic in_valid,
    input wire logic in_first,
    output logic in_ready,
    // payload out
    output logic [7:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    import cmd_sleep_pkg::*;
    logic [3:0] idx_r;
    logic busy_r;
    logic [7:0] addr_byte;
    // msb first, one byte per accepted beat
    assign addr_byte = src_addr[8'(63 - 8 * int'(idx_r)) -: 8];
    assign in_ready = ce && out_ready && !(in_valid && in_first && !busy_r
        && idx_r == 4'h0) && !busy_r;
    assign out_valid = ce && (busy_r || (in_valid && !(in_first &&
        idx_r == 4'h0)));
    assign out_data = busy_r ? addr_byte : in_data;
    // prefix eight address bytes before the first payload byte
    always_ff @(posedge clk) begin
        if (reset) begin
            idx_r <= 4'h0;
            busy_r <= 1'b0;
        end else if (ce) begin
            if (!busy_r && in_valid && in_first && idx_r == 4'h0) begin
                busy_r <= 1'b1;
            end else if (busy_r && out_ready) begin
                if (idx_r == 4'(addr_bytes - 1)) begin
                    busy_r <= 1'b0;
                    idx_r <= 4'hf;
                end else begin
                    idx_r <= idx_r + 4'h1;
                end
            end else if (idx_r == 4'hf && in_valid && out_ready) begin
                idx_r <= 4'h0; // first payload byte passed
            end
        end
    end
endmodule : addr_prefix

// ==== hdl/cmd_sleep_ctrl.sv ====
// command mode and sleep sequencer, axi4-lite registers
// assumes serial rx byte strobes on clk; pins are asynchronous
// Behaviour
// - leave command mode after inactivity period in 100 ms units
// - exit command leaves command mode at once
// - escape needs guard silence before and after the characters
// - escape character is programmable, default plus sign
// - full guard, escape, guard sequence enters command mode
// - sleep mode 0 off, 1 pin sleep, 4 cyclic sleep
// - mode 0 is router; change from 0 to nonzero forces leave and rejoin end device
// - withhold wake indication for count periods when no radio data
// - sleep for period length in 10 ms units
// - parent holds buffered child message for its own period length
// - time-before-sleep timer restarts on serial or radio data
// - option 0x02 stays awake full timer, 0x04 sleeps count times period
// - prefix eight bytes of own 64-bit address to every payload
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module cmd_sleep_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // serial side events
    input wire logic [7:0] rx_byte,
    input wire logic rx_strobe,
    input wire logic cmd_valid,
    input wire logic cmd_exit,
    output logic cmd_mode,
    // radio side
    input wire logic radio_rx,
    input wire logic radio_pending,
    output logic rejoin_end_device,
    output logic end_device,
    output logic [15:0] parent_hold_time,
    // sleep pins
    input wire logic sleep_req_pin,
    output logic low_power,
    output logic wake_ind,
    // payload prefixing
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_first,
    output logic tx_ready,
    output logic [7:0] rf_data,
    output logic rf_valid,
    input wire logic rf_ready
);
    import cmd_sleep_pkg::*;

    // clamp into the legal range
    function automatic logic [15:0] clamp16(input logic [15:0] v,
        input logic [15:0] lo, input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction : clamp16

    logic [15:0] inact_r, guard_r, pcount_r, plen_r, tbs_r;
    logic [7:0] esc_r, sopt_r;
    logic [2:0] smode_r;
    logic [63:0] addr_r;
    cmd_state_t cst_r, cst_nxt;
    sleep_state_t sst_r, sst_nxt;
    logic [15:0] ms_div_r;
    logic [15:0] silence_r, inact_ms_r, tbs_cnt_r, slp_ms_r, per_cnt_r;
    logic [6:0] inact_sub_r;
    logic [1:0] esc_n_r;
    logic rejoin_r, wake_r;
    logic [2:0] pin_sync_r;
    logic pin_lvl_r;
    logic ms_tick, guard_ok, is_esc, inact_done, tbs_done, period_done;
    logic sleep_allowed, wake_ok;

    // pin synchroniser, stages two and three must agree
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_sync_r <= 3'h0;
            pin_lvl_r <= 1'b0;
        end else if (ce) begin
            pin_sync_r <= {pin_sync_r[1:0], sleep_req_pin};
            if (pin_sync_r[2] == pin_sync_r[1]) begin
                pin_lvl_r <= pin_sync_r[2];
            end
        end
    end

    // millisecond tick
    assign ms_tick = (ms_div_r == 16'(cycles_per_ms - 1));
    always_ff @(posedge clk) begin
        if (reset) begin
            ms_div_r <= 16'h0;
        end else if (ce) begin
            ms_div_r <= ms_tick ? 16'h0 : ms_div_r + 16'h1;
        end
    end

    // escape sequence decoding
    assign is_esc = rx_strobe && (rx_byte == esc_r);
    assign guard_ok = (silence_r >= guard_r);
    always_comb begin
        cst_nxt = cst_r;
        case (cst_r)
            cm_idle: if (rx_strobe && is_esc && guard_ok) cst_nxt = cm_arm;
            cm_arm: begin
                if (rx_strobe && !is_esc) begin
                    cst_nxt = cm_idle;
                end else if (is_esc && esc_n_r == 2'(esc_count - 1)) begin
                    cst_nxt = cm_post;
                end
            end
            cm_post: begin
                if (rx_strobe) begin
                    cst_nxt = cm_idle;
                end else if (guard_ok) begin
                    cst_nxt = cm_cmd;
                end
            end
            cm_cmd: begin
                if (cmd_exit) begin
                    cst_nxt = cm_idle;
                end else if (inact_done) begin
                    cst_nxt = cm_idle;
                end
            end
            default: cst_nxt = cm_idle;
        endcase
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            cst_r <= cm_idle;
            esc_n_r <= 2'h0;
        end else if (ce) begin
            cst_r <= cst_nxt;
            if (cst_nxt == cm_arm && cst_r == cm_idle) begin
                esc_n_r <= 2'h1;
            end else if (is_esc) begin
                esc_n_r <= esc_n_r + 2'h1;
            end
        end
    end
    assign cmd_mode = (cst_r == cm_cmd);

    // silence counter, saturating
    always_ff @(posedge clk) begin
        if (reset) begin
            silence_r <= 16'h0;
        end else if (ce) begin
            if (rx_strobe) begin
                silence_r <= 16'h0;
            end else if (ms_tick && silence_r != 16'hffff) begin
                silence_r <= silence_r + 16'h1;
            end
        end
    end

    // inactivity timer in 100 ms units
    assign inact_done = (inact_ms_r >= inact_r);
    always_ff @(posedge clk) begin
        if (reset || ce && (cst_r != cm_cmd || cmd_valid)) begin
            inact_ms_r <= 16'h0;
            inact_sub_r <= 7'h0;
        end else if (ce && ms_tick) begin
            if (inact_sub_r == 7'(ms_per_inact - 1)) begin
                inact_sub_r <= 7'h0;
                inact_ms_r <= inact_ms_r + 16'h1;
            end else begin
                inact_sub_r <= inact_sub_r + 7'h1;
            end
        end
    end

    // time-before-sleep timer
    assign tbs_done = (tbs_cnt_r >= tbs_r);
    always_ff @(posedge clk) begin
        if (reset) begin
            tbs_cnt_r <= 16'h0;
        end else if (ce) begin
            if (rx_strobe || radio_rx || sst_r != sl_awake) begin
                tbs_cnt_r <= 16'h0;
            end else if (ms_tick && !tbs_done) begin
                tbs_cnt_r <= tbs_cnt_r + 16'h1;
            end
        end
    end

    // sleep sequencing; only an end device may sleep
    assign end_device = (smode_r != smode_off);
    assign sleep_allowed = end_device && !cmd_mode && ((smode_r == smode_pin
        && pin_lvl_r) || (smode_r == smode_cyclic && tbs_done));
    assign period_done = (slp_ms_r >= 16'(plen_r * 16'(ms_per_plen)));
    // wake withheld for count periods unless data waits
    assign wake_ok = radio_pending || (per_cnt_r + 16'h1 >= pcount_r);
    always_comb begin
        sst_nxt = sst_r;
        case (sst_r)
            sl_awake: if (sleep_allowed) sst_nxt = sl_sleep;
            sl_sleep: begin
                if (smode_r == smode_pin) begin
                    if (!pin_lvl_r) sst_nxt = sl_wake;
                end else if (!end_device) begin
                    sst_nxt = sl_wake;
                end else if (period_done) begin
                    // full count times period when long option set
                    if (!sopt_r[sopt_long_bit] || wake_ok) sst_nxt = sl_wake;
                end
            end
            sl_wake: sst_nxt = sl_awake;
            default: sst_nxt = sl_awake;
        endcase
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            sst_r <= sl_awake;
            slp_ms_r <= 16'h0;
            per_cnt_r <= 16'h0;
            wake_r <= 1'b1;
        end else if (ce) begin
            sst_r <= sst_nxt;
            if (sst_r != sl_sleep || period_done) begin
                slp_ms_r <= 16'h0;
            end else if (ms_tick) begin
                slp_ms_r <= slp_ms_r + 16'h1;
            end
            if (sst_nxt == sl_wake) begin
                wake_r <= wake_ok || !sopt_r[sopt_long_bit] && wake_ok;
                per_cnt_r <= wake_ok ? 16'h0 : per_cnt_r + 16'h1;
            end else if (sst_r == sl_sleep && period_done && !wake_ok) begin
                per_cnt_r <= per_cnt_r + 16'h1;
            end else if (sst_nxt == sl_sleep) begin
                wake_r <= 1'b0;
            end else if (sst_r == sl_awake && sopt_r[sopt_wake_bit]) begin
                wake_r <= 1'b1;
            end
        end
    end
    assign low_power = (sst_r == sl_sleep);
    assign wake_ind = wake_r;
    assign parent_hold_time = plen_r;

    // axi4-lite write path, aw and w in either order
    logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [1:0] bresp_r, rresp_r;
    logic wr_go, wr_hit, rd_hit;
    logic [31:0] rd_val;
    assign s_axi_awready = ce && !aw_hold_r && !bvalid_r;
    assign s_axi_wready = ce && !w_hold_r && !bvalid_r;
    assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_hit = awaddr_r <= off_addr_hi && awaddr_r[1:0] == 2'b00
        && awaddr_r != off_status;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'b00;
            awaddr_r <= 8'h0;
            wdata_r <= 32'h0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? 2'b00 : 2'b10;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // register updates; 16-bit writes clamp to legal ranges, illegal sleep modes are ignored
    always_ff @(posedge clk) begin
        if (reset) begin
            inact_r <= inact_rst;
            guard_r <= guard_rst;
            esc_r <= esc_rst;
            smode_r <= smode_rst;
            pcount_r <= pcount_rst;
            plen_r <= plen_rst;
            tbs_r <= tbs_rst;
            sopt_r <= sopt_rst;
            addr_r <= 64'h0;
            rejoin_r <= 1'b0;
        end else if (ce) begin
            rejoin_r <= 1'b0;
            if (wr_go && wr_hit) begin
                case (awaddr_r)
                    off_inact: inact_r <= clamp16(wdata_r[15:0], inact_min,
                        inact_max);
                    off_guard: guard_r <= clamp16(wdata_r[15:0], guard_min,
                        guard_max);
                    off_esc: esc_r <= wdata_r[7:0];
                    off_smode: begin
                        if (wdata_r[2:0] == smode_off ||
                            wdata_r[2:0] == smode_pin ||
                            wdata_r[2:0] == smode_cyclic) begin
                            smode_r <= wdata_r[2:0];
                            rejoin_r <= (smode_r == smode_off) &&
                                (wdata_r[2:0] != smode_off);
                        end
                    end
                    off_pcount: pcount_r <= clamp16(wdata_r[15:0], 16'h1,
                        16'hffff);
                    off_plen: plen_r <= clamp16(wdata_r[15:0], plen_min,
                        plen_max);
                    off_tbs: tbs_r <= clamp16(wdata_r[15:0], 16'h1,
                        tbs_max);
                    off_sopt: sopt_r <= wdata_r[7:0];
                    off_addr_lo: addr_r[31:0] <= wdata_r;
                    off_addr_hi: addr_r[63:32] <= wdata_r;
                    default: ;
                endcase
            end
        end
    end
    assign rejoin_end_device = rejoin_r;

    // read path
    assign rd_hit = s_axi_araddr <= off_addr_hi && s_axi_araddr[1:0] == 2'b00;
    always_comb begin
        case (s_axi_araddr)
            off_ctrl: rd_val = 32'h0;
            off_inact: rd_val = {16'h0, inact_r};
            off_guard: rd_val = {16'h0, guard_r};
            off_esc: rd_val = {24'h0, esc_r};
            off_smode: rd_val = {29'h0, smode_r};
            off_pcount: rd_val = {16'h0, pcount_r};
            off_plen: rd_val = {16'h0, plen_r};
            off_tbs: rd_val = {16'h0, tbs_r};
            off_sopt: rd_val = {24'h0, sopt_r};
            off_status: rd_val = {26'h0, cst_r, sst_r, end_device, wake_r};
            off_addr_lo: rd_val = addr_r[31:0];
            off_addr_hi: rd_val = addr_r[63:32];
            default: rd_val = 32'h0;
        endcase
    end
    assign s_axi_arready = ce && !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    always_ff @(posedge clk) begin
        if (reset) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= 2'b00;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_hit ? rd_val : 32'h0;
                rresp_r <= rd_hit ? 2'b00 : 2'b10;
            end else if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // own address first on each payload
    addr_prefix u_prefix (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .src_addr(addr_r),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_first(tx_first),
        .in_ready(tx_ready),
        .out_data(rf_data),
        .out_valid(rf_valid),
        .out_ready(rf_ready)
    );
endmodule : cmd_sleep_ctrl

// ==== sim/cmd_sleep_ctrl_checker.sv ====
// assertions on the sequencer ports
// assumes one clock, sync active-high reset
`timescale 1ns/1ps
module cmd_sleep_ctrl_checker
    import cmd_sleep_pkg::*;
(
    // clock and serial side
    input wire logic clk,
    input wire logic reset,
    input wire logic rx_strobe,
    input wire logic cmd_valid,
    input wire logic cmd_exit,
    input wire logic cmd_mode,
    // sleep and payload side
    input wire logic rejoin_end_device,
    input wire logic end_device,
    input wire logic [15:0] parent_hold_time,
    input wire logic low_power,
    input wire logic [7:0] rf_data,
    input wire logic rf_valid,
    input wire logic rf_ready
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);
    // command mode entry and exit
    AST_EXIT_NOW: assert property (
        cmd_mode && cmd_exit |=> !cmd_mode) else $error("exit ignored");
    AST_GUARD_AFTER: assert property (
        !cmd_mode && rx_strobe |=> !cmd_mode [*8]) else $error("no guard");
    AST_ENTRY_SILENT: assert property (
        $rose(cmd_mode) |-> !$past(rx_strobe)) else $error("entry on byte");
    AST_CMD_KEEPS: assert property (
        cmd_mode && cmd_valid && !cmd_exit |=> cmd_mode)
        else $error("left after a command");
    // sleep mode, end device and period
    AST_REJOIN_ON_CHANGE: assert property (
        $rose(end_device) |-> ##[0:2] rejoin_end_device) else $error("no rejoin");
    AST_REJOIN_ONCE: assert property (
        rejoin_end_device |=> !rejoin_end_device && end_device)
        else $error("bad rejoin pulse");
    AST_SLEEP_END_ONLY: assert property (
        low_power |-> end_device) else $error("router asleep");
    AST_PERIOD_RANGE: assert property (
        parent_hold_time >= plen_min && parent_hold_time <= plen_max)
        else $error("period out of range");
    // payload held while stalled
    AST_RF_HOLD: assert property (
        rf_valid && !rf_ready |=> rf_valid && $stable(rf_data))
        else $error("payload dropped");
    COV_ENTRY: cover property ($rose(cmd_mode));
    COV_REJOIN: cover property (rejoin_end_device);
    COV_STALL: cover property (rf_valid && !rf_ready);
endmodule : cmd_sleep_ctrl_checker
bind cmd_sleep_ctrl cmd_sleep_ctrl_checker chk_u (
    .clk, .reset, .rx_strobe, .cmd_valid, .cmd_exit, .cmd_mode,
    .rejoin_end_device, .end_device, .parent_hold_time, .low_power,
    .rf_data, .rf_valid, .rf_ready);

// ==== sim/host_model.sv ====
// host model driving serial side events
// assumes tasks start just after a rising clk edge
`timescale 1ns/1ps
module host_model (
    // clock
    input wire logic clk,
    // serial events
    output logic [7:0] rx_byte = 8'h00,
    output logic rx_strobe = 1'b0,
    output logic cmd_valid = 1'b0,
    output logic cmd_exit = 1'b0
);
    // quiet line, the host half of the guard time
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle
    // one byte, then the inverse on the data
    task automatic send(input logic [7:0] b);
        rx_byte <= b;
        rx_strobe <= 1'b1;
        @(posedge clk);
        rx_byte <= ~b;
        rx_strobe <= 1'b0;
        @(posedge clk);
    endtask : send
    // one-cycle exit or valid command pulse
    task automatic pulse(input logic ex);
        @(posedge clk);
        {cmd_exit, cmd_valid} <= {ex, ~ex};
        @(posedge clk);
        {cmd_exit, cmd_valid} <= 2'b00;
        @(posedge clk);
    endtask : pulse
endmodule : host_model

// ==== sim/cmd_sleep_ctrl_tb.sv ====
// self-checking bench for the command mode and sleep sequencer
// assumes host_model and the bound checker
`timescale 1ns/1ps
module cmd_sleep_ctrl_tb;
    import cmd_sleep_pkg::*;
    typedef struct packed {
        logic wr;
        logic [7:0] a;
        logic [31:0] d;
        logic [1:0] wrsp;
        logic [31:0] rexp;
        logic [1:0] rrsp;
    } row_t;
    // optional write, then read back
    row_t rows[14] = '{
        '{1'b0, 8'h04, 32'h0, 2'h0, 32'h64, 2'h0},
        '{1'b0, 8'h08, 32'h0, 2'h0, 32'h3e8, 2'h0},
        '{1'b0, 8'h0c, 32'h0, 2'h0, 32'h2b, 2'h0},
        '{1'b0, 8'h10, 32'h0, 2'h0, 32'h0, 2'h0},
        '{1'b0, 8'h14, 32'h0, 2'h0, 32'h1, 2'h0},
        '{1'b0, 8'h18, 32'h0, 2'h0, 32'h20, 2'h0},
        '{1'b0, 8'h1c, 32'h0, 2'h0, 32'h1388, 2'h0},
        '{1'b1, 8'h30, 32'h5, 2'h2, 32'h0, 2'h2},
        '{1'b1, 8'h18, 32'h10, 2'h0, 32'h20, 2'h0},
        '{1'b1, 8'h18, 32'haf0, 2'h0, 32'haf0, 2'h0},
        '{1'b1, 8'h04, 32'h1, 2'h0, 32'h2, 2'h0},
        '{1'b1, 8'h20, 32'h6, 2'h0, 32'h6, 2'h0},
        '{1'b1, 8'h08, 32'h1, 2'h0, 32'h1, 2'h0},
        '{1'b1, 8'h0c, 32'h2a, 2'h0, 32'h2a, 2'h0}
    };
    logic [2:0] modes[6] = '{3'h1, 3'h4, 3'h0, 3'h4, 3'h3, 3'h0};
    logic [7:0] pre[10] = '{8'h01, 8'h23, 8'h45, 8'h67, 8'h89, 8'hab,
        8'hcd, 8'hef, 8'ha5, 8'h5a};
    logic clk = 1'b0, reset = 1'b1, ce = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] rx_byte, rf_data, tx_data = 8'h00;
    logic rx_strobe, cmd_valid, cmd_exit, cmd_mode, rejoin_end_device;
    logic end_device, low_power, wake_ind, tx_ready, rf_valid;
    logic radio_rx = 1'b0, radio_pending = 1'b0, sleep_req_pin = 1'b0;
    logic tx_valid = 1'b0, tx_first = 1'b0, rf_ready = 1'b0;
    logic [15:0] parent_hold_time;
    int n_errors = 0, num_checks = 0, cyc = 0, rejoins = 0;
    logic [7:0] rf_q[$];
    cmd_sleep_ctrl dut_u (.*);
    host_model host_u (.*);
    always #10 clk = ~clk;
    // stalling sink
    always @(posedge clk) begin
        rf_ready <= ~rf_ready;
        if (rf_valid && rf_ready) rf_q.push_back(rf_data);
        if (rejoin_end_device === 1'b1) rejoins++;
        if (++cyc == 110000) begin
            n_errors++;
            finish_test;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : finish_test
    // one bus access
    task automatic axi(input logic wr, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
        logic ad, w, rs;
        @(posedge clk);
        {ad, w, rs} = {1'b1, wr, 1'b1};
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
        {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
        while (rs) begin
            @(negedge clk);
            ad = ad && !(wr ? s_axi_awready : s_axi_arready);
            w = w && !s_axi_wready;
            rs = !(wr ? s_axi_bvalid : s_axi_rvalid);
            {q, r} = {s_axi_rdata, wr ? s_axi_bresp : s_axi_rresp};
            @(posedge clk);
            {s_axi_awvalid, s_axi_wvalid} <= {wr && ad, w};
            s_axi_arvalid <= !wr && ad;
            {s_axi_bready, s_axi_rready} <= {wr && rs, !wr && rs};
        end
    endtask : axi
    // one payload byte
    task automatic send_tx(input logic [7:0] b, input logic f);
        logic ok;
        @(posedge clk);
        {tx_data, tx_first, tx_valid} <= {b, f, 1'b1};
        do begin
            @(negedge clk);
            ok = tx_ready === 1'b1;
            @(posedge clk);
        end while (!ok);
        tx_valid <= 1'b0;
    endtask : send_tx
    // reset, rows, then hand cases
    initial begin
        logic [31:0] q;
        logic [1:0] r;
        logic [2:0] cur;
        int rj;
        cur = 3'h0;
        rj = 0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("reset cmd", 32'h0, {31'h0, cmd_mode});
        chk("reset wake", 32'h1, {31'h0, wake_ind});
        chk("reset end dev", 32'h0, {31'h0, end_device});
        @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].wr) axi(1'b1, rows[i].a, rows[i].d, q, r);
            if (rows[i].wr) chk("wr resp", {30'h0, rows[i].wrsp}, {30'h0, r});
            axi(1'b0, rows[i].a, 32'h0, q, r);
            chk("rd data", rows[i].rexp, q);
            chk("rd resp", {30'h0, rows[i].rrsp}, {30'h0, r});
        end
        chk("hold time", 32'haf0, {16'h0, parent_hold_time});
        $display("register test done");
        // mode 3 is illegal and ignored
        foreach (modes[i]) begin
            axi(1'b1, 8'h10, {29'h0, modes[i]}, q, r);
            if (modes[i] inside {3'h0, 3'h1, 3'h4}) begin
                rj += int'(cur == 3'h0 && modes[i] != 3'h0);
                cur = modes[i];
            end
            axi(1'b0, 8'h10, 32'h0, q, r);
            chk("sleep mode", {29'h0, cur}, q);
            chk("end dev", {31'h0, cur != 3'h0}, {31'h0, end_device});
            chk("rejoins", rj, rejoins);
        end
        $display("sleep mode test done");
        axi(1'b1, 8'h28, 32'h89abcdef, q, r);
        axi(1'b1, 8'h2c, 32'h01234567, q, r);
        send_tx(8'ha5, 1'b1);
        send_tx(8'h5a, 1'b0);
        repeat (8) @(posedge clk);
        foreach (pre[i]) chk("rf byte", {24'h0, pre[i]}, {24'h0, rf_q[i]});
        chk("rf count", 32'd10, rf_q.size());
        $display("prefix test done");
        ce <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chk("frozen", 32'h0, {31'h0, s_axi_awready});
        ce <= 1'b1;
        host_u.idle(52000);
        repeat (3) host_u.send(8'h2a);
        host_u.idle(50);
        #1 chk("early entry", 32'h0, {31'h0, cmd_mode});
        host_u.idle(52000);
        #1 chk("entry", 32'h1, {31'h0, cmd_mode});
        host_u.pulse(1'b0);
        #1 chk("stay", 32'h1, {31'h0, cmd_mode});
        host_u.pulse(1'b1);
        #1 chk("exit", 32'h0, {31'h0, cmd_mode});
        $display("escape test done");
        finish_test;
    end
endmodule : cmd_sleep_ctrl_tb
